// >>> hw/ext_port.sv
// External memory port pin engine.
`default_nettype none
module ext_port
  import ext_port_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  // Core request side
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  output logic                   req_ready_o,
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  // SDRAM command request
  input  wire logic              sd_valid_i,
  input  wire logic [2:0]        sd_cmd_i,
  output logic                   sd_ready_o,
  // Pin function selection
  input  wire logic [DATA_W-1:0] par_sel_i,
  input  wire logic [DATA_W-1:0] flag_sel_i,
  input  wire logic [DATA_W-1:0] pwm_sel_i,
  input  wire logic [DATA_W-1:0] flag_out_i,
  input  wire logic [DATA_W-1:0] pwm_out_i,
  input  wire logic              par_ch0_en_i,
  output logic [DATA_W-1:0]      par_data_o,
  output logic                   par_valid_o,
  output logic [DATA_W-1:0]      flag_in_o,
  // External pins
  output logic [ADDR_W-1:0]      addr_o,
  input  wire logic [DATA_W-1:0] data_i,
  output logic [DATA_W-1:0]      data_o,
  output logic [DATA_W-1:0]      data_oe_n_o,
  input  wire logic              ack_i,
  output logic                   rd_n_o,
  output logic                   wr_n_o,
  output logic [BANKS-1:0]       bank_select_n_o,
  output logic                   sdram_row_strobe_o,
  output logic                   sdram_column_strobe_o,
  output logic                   sdram_write_enable_o
);
  port_state_t            state_q;
  logic [1:0]             mode_q [DATA_W];
  logic                   out_of_reset_q;
  logic                   buf_ready;
  logic                   start;
  req_buf_if              rq ();

  function automatic logic [BANKS-1:0] bank_decode(
    input logic [ADDR_W-1:0] a);
    logic [BANKS-1:0] r;
    r = '1;
    r[a[BANK_LSB +: 1]] = 1'b0;
    return r;
  endfunction

  req_buf2 u_buf (
    .clk_i      (clk_i),
    .rstn_i     (rstn_i),
    .in_valid_i (req_valid_i),
    .in_req_i   ({req_write_i, req_addr_i, req_wdata_i}),
    .in_ready_o (buf_ready),
    .out        (rq.src)
  );

  assign start    = (state_q == ST_IDLE) && rq.valid;
  assign rq.ready = start;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      req_ready_o <= 1'b0;
      sd_ready_o  <= 1'b0;
    end
    else
    begin
      req_ready_o <= buf_ready;
      sd_ready_o  <= (state_q == ST_IDLE) && !rq.valid;
    end
  end

  // Pin modes: memory interface after reset, low flag pins in flag mode.
  always_ff @(posedge clk_i)
  begin
    for (int i = 0; i < DATA_W; i++)
    begin
      if (!rstn_i)
      begin
        mode_q[i] <= (i < FLAG_PINS) ? MODE_FLAG : MODE_MEM;
      end
      else if (par_sel_i[i])
      begin
        mode_q[i] <= MODE_PAR;
      end
      else if (flag_sel_i[i])
      begin
        mode_q[i] <= MODE_FLAG;
      end
      else if (pwm_sel_i[i])
      begin
        mode_q[i] <= MODE_PWM;
      end
      else
      begin
        mode_q[i] <= mode_q[i];
      end
    end
  end

  // Access sequencing and strobes.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      state_q     <= ST_IDLE;
      rd_n_o      <= 1'b1;
      wr_n_o      <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
    end
    else
    begin
      rsp_valid_o <= 1'b0;
      unique case (state_q)
        ST_IDLE:
        begin
          if (start)
          begin
            state_q <= rq.req.write ? ST_WRITE : ST_READ;
            rd_n_o  <= rq.req.write;
            wr_n_o  <= !rq.req.write;
          end
          else if (sd_valid_i)
          begin
            state_q <= ST_SDRAM;
          end
        end
        ST_READ, ST_WRITE:
        begin
          if (ack_i)
          begin
            state_q     <= ST_IDLE;
            rd_n_o      <= 1'b1;
            wr_n_o      <= 1'b1;
            rsp_valid_o <= 1'b1;
            rsp_rdata_o <= (state_q == ST_READ) ? data_i : '0;
          end
        end
        ST_SDRAM:
        begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Address and bank selects change on the same edge.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      addr_o          <= ADDR_RST;
      bank_select_n_o <= '1;
      out_of_reset_q  <= 1'b0;
    end
    else
    begin
      out_of_reset_q <= 1'b1;
      if (start)
      begin
        addr_o          <= rq.req.addr;
        bank_select_n_o <= bank_decode(rq.req.addr);
      end
      else if (state_q == ST_IDLE)
      begin
        addr_o          <= ADDR_IDLE;
        bank_select_n_o <= '1;
      end
    end
  end

  // SDRAM command pins.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      {sdram_row_strobe_o, sdram_column_strobe_o,
       sdram_write_enable_o} <= SD_NOP;
    end
    else if (state_q == ST_IDLE && !start && sd_valid_i)
    begin
      {sdram_row_strobe_o, sdram_column_strobe_o,
       sdram_write_enable_o} <= sd_cmd_i;
    end
    else
    begin
      {sdram_row_strobe_o, sdram_column_strobe_o,
       sdram_write_enable_o} <= SD_NOP;
    end
  end

  // Shared data pin drive and capture.
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      data_o      <= '0;
      data_oe_n_o <= '1;
      par_data_o  <= '0;
      par_valid_o <= 1'b0;
      flag_in_o   <= '0;
    end
    else
    begin
      par_valid_o <= par_ch0_en_i && out_of_reset_q;
      for (int i = 0; i < DATA_W; i++)
      begin
        flag_in_o[i] <= data_i[i];
        if (mode_q[i] == MODE_PAR && par_ch0_en_i)
        begin
          par_data_o[i] <= data_i[i];
        end
        unique case (mode_q[i])
          MODE_MEM:
          begin
            if (start)
            begin
              data_o[i]      <= rq.req.data[i];
            end
            data_oe_n_o[i] <= !(start && rq.req.write);
            if (state_q == ST_WRITE && !ack_i)
            begin
              data_oe_n_o[i] <= 1'b0;
            end
          end
          MODE_FLAG:
          begin
            data_o[i]      <= flag_out_i[i];
            data_oe_n_o[i] <= 1'b0;
          end
          MODE_PWM:
          begin
            data_o[i]      <= pwm_out_i[i];
            data_oe_n_o[i] <= 1'b0;
          end
          MODE_PAR:
          begin
            data_o[i]      <= 1'b0;
            data_oe_n_o[i] <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // ext_port
`default_nettype wire

// >>> hw/ext_port_pkg.sv
// Constants and types for the external memory port pin block.
// Function
// - 24-bit address out, high in reset, low after
// - Shared data pins default to memory-interface mode, the low FLAG_PINS pins to flag mode
// - Input port channel 0 samples data pins
// - Low acknowledge stretches the current access
// - Read strobe low per word read only
// - Write strobe low per word written only
// - SDRAM strobes encode command, high after reset
// - Bank selects decoded from address, change together
`default_nettype none
package ext_port_pkg;
  localparam int          ADDR_W      = 24;
  localparam int          DATA_W      = 32;
  localparam int          BANKS       = 2;
  localparam int          BANK_LSB    = 22;
  localparam int          FLAG_PINS   = 4;
  localparam logic [23:0] ADDR_RST    = 24'hffffff;
  localparam logic [23:0] ADDR_IDLE   = 24'h000000;
  localparam logic [1:0]  MODE_MEM    = 2'h0;
  localparam logic [1:0]  MODE_PAR    = 2'h1;
  localparam logic [1:0]  MODE_FLAG   = 2'h2;
  localparam logic [1:0]  MODE_PWM    = 2'h3;
  localparam logic [2:0]  SD_NOP      = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_SDRAM
  } port_state_t;

  typedef struct packed {
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } mem_req_t;
endpackage
`default_nettype wire

// >>> hw/req_buf2.sv
// Two-entry buffer for memory requests.
`default_nettype none
module req_buf2
  import ext_port_pkg::*;
(
  // Clock and reset
  input  wire logic     clk_i,
  input  wire logic     rstn_i,
  // Filling side
  input  wire logic     in_valid_i,
  input  wire mem_req_t in_req_i,
  output logic          in_ready_o,
  // Draining side
  req_buf_if.src        out
);
  mem_req_t   mem_q [2];
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic [1:0] cnt_q;
  logic       push;
  logic       pop;

  assign in_ready_o = (cnt_q != 2'h2);
  assign out.valid  = (cnt_q != 2'h0);
  assign out.req    = mem_q[rd_ptr_q];
  assign push       = in_valid_i && in_ready_o;
  assign pop        = out.valid && out.ready;

  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_req_i;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop)
      begin
        rd_ptr_q <= !rd_ptr_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // req_buf2
`default_nettype wire

// >>> hw/req_buf_if.sv
// Valid/ready carrier between the request buffer and the port engine.
`default_nettype none
interface req_buf_if;
  import ext_port_pkg::*;
  logic     valid;
  logic     ready;
  mem_req_t req;
  modport src (output valid, output req, input ready);
  modport dst (input valid, input req, output ready);
endinterface
`default_nettype wire

// >>> test/ext_mem_model.sv
// Asynchronous memory model on the far side of the port.
`default_nettype none
module ext_mem_model
  import ext_port_pkg::*;
(
  // Clock
  input wire logic              clk_i,
  // Wait states per access
  input wire logic [3:0]        waits_i,
  // Port pins
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wire_i,
  input wire logic              rd_n_i,
  input wire logic              wr_n_i,
  output logic                  ack_o,
  output logic [DATA_W-1:0]     data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [DATA_W-1:0] mem_q [16];
  logic [3:0]        cnt_q;
  logic              idle;
  assign idle = rd_n_i !== 1'b0 && wr_n_i !== 1'b0;
  // Acknowledge is held low for the chosen number of cycles.
  assign ack_o = idle || cnt_q >= waits_i;
  // Released data pins float to the pull-up level.
  assign data_o = rd_n_i !== 1'b0 ? '1 : mem_q[addr_i[3:0]];
  always_ff @(posedge clk_i)
  begin
    if (idle)
      cnt_q <= 4'h0;
    else if (!ack_o)
      cnt_q <= cnt_q + 4'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (!wr_n_i && ack_o)
      mem_q[addr_i[3:0]] <= wire_i;
  end
endmodule // ext_mem_model
`default_nettype wire

// >>> test/ext_port_asserts.sv
// Concurrent checks on the external memory port pins.
`default_nettype none
module ext_port_asserts
  import ext_port_pkg::*;
(
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rstn_i,
  // Pins and response
  input wire logic              ack_i,
  input wire logic              rd_n_o,
  input wire logic              wr_n_o,
  input wire logic              rsp_valid_o,
  input wire logic [ADDR_W-1:0] addr_o,
  input wire logic [BANKS-1:0]  bank_select_n_o,
  input wire logic              sdram_row_strobe_o,
  input wire logic              sdram_column_strobe_o,
  input wire logic              sdram_write_enable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] sd;
  assign sd = {sdram_row_strobe_o, sdram_column_strobe_o,
    sdram_write_enable_o};
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_busy;
    !rd_n_o || !wr_n_o;
  endsequence
  a_reset_pins: assert property (
    $rose(rstn_i) |-> addr_o == ADDR_RST && rd_n_o && wr_n_o &&
    sd == SD_NOP && &bank_select_n_o) else $error("bad reset pins");
  a_addr_idle: assert property (
    $rose(rstn_i) |=> addr_o == ADDR_IDLE) else $error("bad idle address");
  a_ack_wait: assert property (
    s_busy ##0 !ack_i |=> s_busy ##0 $stable(addr_o))
    else $error("access ended without acknowledge");
  a_ack_done: assert property (
    s_busy ##0 ack_i |=> rd_n_o && wr_n_o && rsp_valid_o)
    else $error("access not finished on acknowledge");
  a_rsp_cause: assert property (
    rsp_valid_o |-> $past(ack_i) && !($past(rd_n_o) && $past(wr_n_o)))
    else $error("response without acknowledged strobe");
  a_one_strobe: assert property (
    rd_n_o || wr_n_o) else $error("both strobes low");
  a_bank_decode: assert property (
    s_busy |-> bank_select_n_o == ~(2'h1 << addr_o[BANK_LSB]))
    else $error("bad bank select");
  a_sd_pulse: assert property (
    sd != SD_NOP |=> sd == SD_NOP) else $error("command not one cycle");
endmodule // ext_port_asserts
`default_nettype wire

// >>> test/ext_port_tb.sv
// Self-checking bench for the external memory port pins.
`default_nettype none
module ext_port_tb;
  import ext_port_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_i = 1'b0, rstn_i = 1'b0, req_valid_i = 1'b0;
  logic              req_write_i = 1'b0, sd_valid_i = 1'b0;
  logic              par_ch0_en_i = 1'b0, ack_i, rd_n_o, wr_n_o;
  logic              req_ready_o, rsp_valid_o, sd_ready_o, par_valid_o;
  logic              sdram_row_strobe_o, sdram_column_strobe_o;
  logic              sdram_write_enable_o;
  logic [2:0]        sd_cmd_i = 3'h0;
  logic [3:0]        waits = 4'hf;
  logic [BANKS-1:0]  bank_select_n_o;
  logic [ADDR_W-1:0] req_addr_i = '0, addr_o;
  logic [DATA_W-1:0] req_wdata_i = '0, par_sel_i = '0, data_i, data_o;
  logic [DATA_W-1:0] data_oe_n_o, rsp_rdata_o, par_data_o, flag_in_o;
  logic [DATA_W-1:0] got[$];
  int                miscompares = 0, n_tests = 0;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (rsp_valid_o === 1'b1)
      got.push_back(rsp_rdata_o);
  ext_port ext_port_i (.*, .flag_sel_i('0), .pwm_sel_i('0),
    .flag_out_i('0), .pwm_out_i('0));
  ext_mem_model ext_mem_model_i (.clk_i, .waits_i(waits), .addr_i(addr_o),
    .wire_i(data_o | data_oe_n_o), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o),
    .ack_o(ack_i), .data_o(data_i));
  task automatic chk(input logic [31:0] v, input logic [31:0] e);
    n_tests++;
    if (v !== e)
    begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, v, e);
    end
  endtask
  task automatic summarize;
    $display("%0d compares, %0d miscompares", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic push(input logic w, input logic [23:0] a,
    input logic [31:0] d);
    for (int i = 0; i < 50; i++)
    begin
      @(posedge clk_i);
      if (req_ready_o === 1'b1)
        break;
    end
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_addr_i <= a;
    req_wdata_i <= d;
    @(posedge clk_i);
    req_valid_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic take(input logic [31:0] e);
    for (int i = 0; i < 200 && got.size() == 0; i++)
      @(posedge clk_i);
    if (got.size() == 0)
      got.push_back('x);
    chk(got.pop_front() & 32'hfffffff0, e & 32'hfffffff0);
  endtask
  task automatic t_access;
    push(1'b1, 24'h000003, 32'h12345678);
    push(1'b1, 24'h400005, 32'h9abcdef0);
    push(1'b0, 24'h000003, '0);
    @(posedge clk_i);
    chk({31'h0, req_ready_o}, 32'h0);
    push(1'b0, 24'h400005, '0);
    take('0);
    take('0);
    take(32'h12345678);
    take(32'h9abcdef0);
  endtask
  task automatic t_nowait;
    waits <= 4'h0;
    push(1'b1, 24'h000007, 32'h0badf00d);
    push(1'b0, 24'h000007, '0);
    take('0);
    take(32'h0badf00d);
  endtask
  task automatic t_sd;
    for (int c = 0; c < 7; c++)
    begin
      for (int i = 0; i < 20; i++)
      begin
        @(posedge clk_i);
        if (sd_ready_o === 1'b1)
          break;
      end
      sd_valid_i <= 1'b1;
      sd_cmd_i <= c[2:0];
      @(posedge clk_i);
      sd_valid_i <= 1'b0;
      @(posedge clk_i);
      chk({29'h0, sdram_row_strobe_o, sdram_column_strobe_o,
        sdram_write_enable_o}, {29'h0, c[2:0]});
    end
  endtask
  task automatic t_par;
    par_ch0_en_i <= 1'b1;
    par_sel_i <= '1;
    @(posedge clk_i);
    par_sel_i <= '0;
    repeat (4) @(posedge clk_i);
    chk(par_data_o, '1);
    chk(flag_in_o, '1);
    chk({31'h0, par_valid_o}, 32'h1);
    chk(data_oe_n_o, '1);
  endtask
  initial
  begin
    repeat (3000) @(posedge clk_i);
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (10) @(posedge clk_i);
    chk({8'h0, addr_o}, {8'h0, ADDR_RST});
    chk(data_oe_n_o, '1);
    chk({27'h0, rd_n_o, wr_n_o, bank_select_n_o,
      sdram_row_strobe_o}, 32'h1f);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({8'h0, addr_o}, 32'h0);
    t_access();
    t_nowait();
    t_sd();
    t_par();
    summarize();
  end
endmodule // ext_port_tb
bind ext_port ext_port_asserts ext_port_asserts_i (.*);
`default_nettype wire
